// file: rtl/fpgr_fan_pin_io.sv
// Fan pin alternate-IO registers and pin multiplexers
`default_nettype none
// How it works
// - Enable bit 3..0 repurposes pin 1..4
// - Direction bit: 1 output, 0 input
// - Polarity bit: 1 active high, 0 low
// - Output data from min duty LSB
// - Input status bit read-only, shows asserted level
// - Output status bit writable, asserts the pin
// - Status bits 7..4 map pins 4..1
// - Status meaningful only while pin repurposed
// - Status bits 3:0 are test bits
// - All three registers reset to zero
module fpgr_fan_pin_io
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [fpgr_pkg::FPGR_NUM_CH-1:0] fan_pulse,
    input wire logic [fpgr_pkg::FPGR_NUM_CH-1:0] min_duty_lsb,
    input wire logic [fpgr_pkg::FPGR_NUM_CH-1:0] fan_drive_pin_in,
    output logic [fpgr_pkg::FPGR_NUM_CH-1:0] fan_drive_pin_out,
    output logic [fpgr_pkg::FPGR_NUM_CH-1:0] fan_drive_pin_oe
);
    import fpgr_pkg::*;

    logic [7:0] io_enable_q;
    logic [7:0] dir_pol_q;
    logic [7:0] level_state_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [FPGR_NUM_CH-1:0] alt_io_select;
    logic [FPGR_NUM_CH-1:0] dir_out;
    logic [FPGR_NUM_CH-1:0] active_level;
    logic [FPGR_NUM_CH-1:0] state_bit;
    logic [FPGR_NUM_CH-1:0] in_asserted;
    logic [FPGR_NUM_CH-1:0] pin_out_d;
    logic [FPGR_NUM_CH-1:0] pin_oe_d;
    logic [FPGR_NUM_CH-1:0] pin_out_q;
    logic [FPGR_NUM_CH-1:0] pin_oe_q;
    logic [FPGR_NUM_CH-1:0] stat_view;
    logic [FPGR_NUM_CH-1:0] stat_wr_ok;
    logic wr_en;
    logic wr_cfg;
    logic wr_stat;

    assign wr_en = reg_wr && (reg_addr == FPGR_OFS_IO_ENABLE);
    assign wr_cfg = reg_wr && (reg_addr == FPGR_OFS_DIR_POL);
    assign wr_stat = reg_wr && (reg_addr == FPGR_OFS_LEVEL_STATE);

    // Per-channel field extraction and pin muxes
    genvar gi;
    generate
        for (gi = 0; gi < FPGR_NUM_CH; gi++)
        begin : g_ch
            assign alt_io_select[gi] = io_enable_q[FPGR_EN_BIT_CH1-gi];
            assign dir_out[gi] = dir_pol_q[FPGR_DIR_BIT_CH1-FPGR_CFG_STRIDE*gi];
            assign active_level[gi] = dir_pol_q[FPGR_POL_BIT_CH1-FPGR_CFG_STRIDE*gi];
            assign state_bit[gi] = level_state_q[FPGR_STAT_BIT_CH1+gi];
            // Output channels accept status writes, inputs do not
            assign stat_wr_ok[gi] = alt_io_select[gi] & dir_out[gi];
            // Status view: stored bit for outputs, live asserted level for inputs
            assign stat_view[gi] = !alt_io_select[gi] ? 1'b0 :
                (dir_out[gi] ? state_bit[gi] : in_asserted[gi]);
            fpgr_pin_chan u_chan
            (
                .alt_io_select(alt_io_select[gi]),
                .dir_out(dir_out[gi]),
                .active_level(active_level[gi]),
                .level_state(state_bit[gi]),
                .duty_lsb(min_duty_lsb[gi]),
                .fan_pulse(fan_pulse[gi]),
                .pin_in(fan_drive_pin_in[gi]),
                .pin_out_d(pin_out_d[gi]),
                .pin_oe_d(pin_oe_d[gi]),
                .in_asserted(in_asserted[gi])
            );
        end
    endgenerate

    // Enable register; reserved upper bits stored as written
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            io_enable_q <= FPGR_RST_IO_ENABLE;
        else if (wr_en)
            io_enable_q <= reg_wdata;
    end

    // Direction and polarity register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dir_pol_q <= FPGR_RST_DIR_POL;
        else if (wr_cfg)
            dir_pol_q <= reg_wdata;
    end

    // Level state: test bits always writable, channel bits only as outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            level_state_q <= FPGR_RST_LEVEL_STATE;
        else if (wr_stat)
        begin
            level_state_q[FPGR_TEST_MSB:0] <= reg_wdata[FPGR_TEST_MSB:0];
            for (int i = 0; i < FPGR_NUM_CH; i++)
            begin
                if (stat_wr_ok[i])
                    level_state_q[FPGR_STAT_BIT_CH1+i] <= reg_wdata[FPGR_STAT_BIT_CH1+i];
            end
        end
    end

    // Read mux; unmapped offsets answer zero
    always_comb
    begin
        rdata_d = 8'h00;
        case (reg_addr)
            FPGR_OFS_IO_ENABLE: rdata_d = io_enable_q;
            FPGR_OFS_DIR_POL: rdata_d = dir_pol_q;
            FPGR_OFS_LEVEL_STATE: rdata_d = {stat_view, level_state_q[FPGR_TEST_MSB:0]};
            default: rdata_d = 8'h00;
        endcase
    end

    // Read answer one cycle after the strobe; data held until next read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= reg_rd;
            if (reg_rd)
                rdata_q <= rdata_d;
        end
    end

    // Registered pins avoid glitches when fields change mid-cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_q <= '0;
            pin_oe_q <= '1; // Fan pulse outputs drive from reset
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign fan_drive_pin_out = pin_out_q;
    assign fan_drive_pin_oe = pin_oe_q;

    // Checks
    property p_fan_route;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ((pin_out_q ^ $past(fan_pulse)) & ~$past(alt_io_select)) == '0;
    endproperty
    a_fan_route: assert property (p_fan_route)
        else $error("Disabled pin does not carry fan pulse");

    property p_disabled_drives;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> (~$past(alt_io_select) & ~pin_oe_q) == '0;
    endproperty
    a_disabled_drives: assert property (p_disabled_drives)
        else $error("Disabled pin not driven");

    property p_input_released;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ($past(alt_io_select & ~dir_out) & pin_oe_q) == '0;
    endproperty
    a_input_released: assert property (p_input_released)
        else $error("Input pin still driven");

    property p_out_level;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ($past(alt_io_select & dir_out & (state_bit | min_duty_lsb))
            & (pin_out_q ^ $past(active_level))) == '0;
    endproperty
    a_out_level: assert property (p_out_level)
        else $error("Asserted output not at polarity level");

    property p_duty_data;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ($past(alt_io_select & dir_out & ~state_bit)
            & (pin_out_q ^ ~($past(min_duty_lsb) ^ $past(active_level)))) == '0;
    endproperty
    a_duty_data: assert property (p_duty_data)
        else $error("Output data does not follow duty LSB");

    property p_en_readback;
        @(posedge clk) disable iff (!rst_n)
        (wr_en ##1 (reg_rd && !reg_wr && reg_addr == FPGR_OFS_IO_ENABLE))
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_en_readback: assert property (p_en_readback)
        else $error("Enable register readback mismatch");

    property p_stat_input;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == FPGR_OFS_LEVEL_STATE && alt_io_select[0] && !dir_out[0])
        |=> reg_rdata[FPGR_STAT_BIT_CH1] == ~($past(fan_drive_pin_in[0]) ^ $past(active_level[0]));
    endproperty
    a_stat_input: assert property (p_stat_input)
        else $error("Input status does not show asserted level");

    property p_stat_idle;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == FPGR_OFS_LEVEL_STATE)
        |=> (reg_rdata[7:4] & ~$past(alt_io_select)) == '0;
    endproperty
    a_stat_idle: assert property (p_stat_idle)
        else $error("Status of non-repurposed pin not zero");

    property p_stat_rdonly;
        @(posedge clk) disable iff (!rst_n)
        (wr_stat && !dir_out[3]) |=> $stable(level_state_q[FPGR_STAT_BIT_CH1+3]);
    endproperty
    a_stat_rdonly: assert property (p_stat_rdonly)
        else $error("Input status bit was written");

    property p_rd_pulse;
        @(posedge clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd));
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("Read answer timing wrong");

    property p_stat_out_write;
        @(posedge clk) disable iff (!rst_n)
        wr_stat |=> ((level_state_q[7:4] ^ $past(reg_wdata[7:4])) & $past(stat_wr_ok)) == '0;
    endproperty
    a_stat_out_write: assert property (p_stat_out_write)
        else $error("Output status bit not written");

    property p_test_bits;
        @(posedge clk) disable iff (!rst_n)
        wr_stat |=> level_state_q[FPGR_TEST_MSB:0] == $past(reg_wdata[FPGR_TEST_MSB:0]);
    endproperty
    a_test_bits: assert property (p_test_bits)
        else $error("Test bits not stored as written");

    property p_stat_out_view;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == FPGR_OFS_LEVEL_STATE)
        |=> ((reg_rdata[7:4] ^ $past(level_state_q[7:4])) & $past(alt_io_select & dir_out)) == '0;
    endproperty
    a_stat_out_view: assert property (p_stat_out_view)
        else $error("Output status not read back in place");

    property p_stat_in_all;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == FPGR_OFS_LEVEL_STATE)
        |=> ((reg_rdata[7:4] ^ ~$past(fan_drive_pin_in ^ active_level))
            & $past(alt_io_select & ~dir_out)) == '0;
    endproperty
    a_stat_in_all: assert property (p_stat_in_all)
        else $error("Input status wrong on some channel");

    property p_cfg_readback;
        @(posedge clk) disable iff (!rst_n)
        (wr_cfg ##1 (reg_rd && !reg_wr && reg_addr == FPGR_OFS_DIR_POL))
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("Config register readback mismatch");

    property p_out_drives;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ($past(alt_io_select & dir_out) & ~pin_oe_q) == '0;
    endproperty
    a_out_drives: assert property (p_out_drives)
        else $error("Output pin not driven");

    // Two edges into reset so the async clear has surely landed
    property p_rst_regs;
        @(posedge clk)
        (!rst_n ##1 !rst_n) |-> io_enable_q == FPGR_RST_IO_ENABLE
            && dir_pol_q == FPGR_RST_DIR_POL && level_state_q == FPGR_RST_LEVEL_STATE
            && pin_oe_q == '1 && pin_out_q == '0 && !reg_rvalid;
    endproperty
    a_rst_regs: assert property (p_rst_regs)
        else $error("Registers not at reset values");

    c_out_mode: cover property (@(posedge clk) disable iff (!rst_n)
        alt_io_select[0] && dir_out[0] && pin_oe_q[0]);
    c_in_read: cover property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == FPGR_OFS_LEVEL_STATE && alt_io_select[3] && !dir_out[3]);
    c_stat_write: cover property (@(posedge clk) disable iff (!rst_n)
        wr_stat && stat_wr_ok[1]);
    c_b2b_read: cover property (@(posedge clk) disable iff (!rst_n)
        wr_en ##1 (reg_rd && reg_addr == FPGR_OFS_IO_ENABLE));
endmodule : fpgr_fan_pin_io
`default_nettype wire

// file: rtl/fpgr_pin_chan.sv
// One fan pin: fan pulse or alternate IO, with polarity and direction
`default_nettype none
module fpgr_pin_chan
(
    input wire logic alt_io_select,
    input wire logic dir_out,
    input wire logic active_level,
    input wire logic level_state,
    input wire logic duty_lsb,
    input wire logic fan_pulse,
    input wire logic pin_in,
    output logic pin_out_d,
    output logic pin_oe_d,
    output logic in_asserted
);
    logic assert_req;

    // Either the stored state bit or the duty LSB asserts the output
    assign assert_req = level_state | duty_lsb;

    // Polarity maps asserted to a pin level; 1 = active high
    assign in_asserted = ~(pin_in ^ active_level);

    // Pin mux: fan pulse when not repurposed, else IO per direction
    always_comb
    begin
        if (!alt_io_select)
        begin
            pin_out_d = fan_pulse;
            pin_oe_d = 1'b1;
        end
        else if (dir_out)
        begin
            pin_out_d = ~(assert_req ^ active_level);
            pin_oe_d = 1'b1;
        end
        else
        begin
            // Input: release the pin, park the data low
            pin_out_d = 1'b0;
            pin_oe_d = 1'b0;
        end
    end
endmodule : fpgr_pin_chan
`default_nettype wire

// file: rtl/fpgr_pkg.sv
// Constants shared by the fan pin alternate-IO block
`default_nettype none
package fpgr_pkg;
    // Register offsets on the serial register port
    localparam logic [7:0] FPGR_OFS_IO_ENABLE = 8'h7f;
    localparam logic [7:0] FPGR_OFS_DIR_POL = 8'h80;
    localparam logic [7:0] FPGR_OFS_LEVEL_STATE = 8'h81;
    // Values after reset
    localparam logic [7:0] FPGR_RST_IO_ENABLE = 8'h00;
    localparam logic [7:0] FPGR_RST_DIR_POL = 8'h00;
    localparam logic [7:0] FPGR_RST_LEVEL_STATE = 8'h00;
    // Channel count and field positions (channel 1 positions, then stride)
    localparam int FPGR_NUM_CH = 4;
    localparam int FPGR_EN_BIT_CH1 = 3;
    localparam int FPGR_DIR_BIT_CH1 = 7;
    localparam int FPGR_POL_BIT_CH1 = 6;
    localparam int FPGR_CFG_STRIDE = 2;
    localparam int FPGR_STAT_BIT_CH1 = 4;
    localparam int FPGR_TEST_MSB = 3;
    localparam int FPGR_RSVD_EN_LSB = 4;
    // Read answer latency in clock cycles
    localparam int FPGR_RD_LATENCY = 1;
endpackage : fpgr_pkg
`default_nettype wire

// file: rtl/unused_placeholder_none.sv
// Intentionally empty design file
`default_nettype none
`default_nettype wire

// file: tb/fan_pin_gpio_reuse_test.sv
// Self-checking bench for the fan pin alternate-IO block
`default_nettype none
module fan_pin_gpio_reuse_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fpgr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [3:0] fan_pulse = 4'h0;
    logic [3:0] min_duty_lsb = 4'h0;
    logic [3:0] pin_level;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] drv_val = 4'h0;
    logic [3:0] drv_en = 4'h0;
    logic [7:0] en_m = 8'h00;
    logic [7:0] cfg_m = 8'h00;
    logic [7:0] stat_m = 8'h00;
    logic [7:0] exp_p;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    fpgr_fan_pin_io dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .fan_pulse(fan_pulse), .min_duty_lsb(min_duty_lsb), .fan_drive_pin_in(pin_level),
        .fan_drive_pin_out(pin_out), .fan_drive_pin_oe(pin_oe));
    fpgr_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .drv_val(drv_val),
        .drv_en(drv_en), .pin_level(pin_level));
    // Free-running 10 MHz clock
    initial
    begin
        forever #50 clk = ~clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Write strobe for one cycle; mirror keeps only what the device accepts
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        if (a == FPGR_OFS_IO_ENABLE)
            en_m = d;
        else if (a == FPGR_OFS_DIR_POL)
            cfg_m = d;
        else if (a == FPGR_OFS_LEVEL_STATE)
        begin
            stat_m[3:0] = d[3:0];
            for (int c = 0; c < 4; c++)
                if (en_m[3-c] && cfg_m[7-2*c])
                    stat_m[4+c] = d[4+c];
        end
    endtask : wr
    // Read answer is looked at in the one cycle it stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
    endtask : rd
    // Write, then read the same place in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check(reg_rdata, d);
    endtask : wr_rd
    function automatic logic [7:0] exp_stat(input logic [7:0] en, input logic [7:0] cfg,
        input logic [7:0] st, input logic [3:0] pin);
        logic [7:0] r;
        r = {4'h0, st[3:0]};
        for (int c = 0; c < 4; c++)
            if (en[3-c])
                r[4+c] = cfg[7-2*c] ? st[4+c] : (pin[c] == cfg[6-2*c]);
        return r;
    endfunction : exp_stat
    // Expected {oe, out} for all four pins
    function automatic logic [7:0] exp_pins(input logic [7:0] en, input logic [7:0] cfg,
        input logic [7:0] st, input logic [3:0] duty, input logic [3:0] fp);
        logic [3:0] o;
        logic [3:0] e;
        for (int c = 0; c < 4; c++)
        begin
            o[c] = en[3-c] ? 1'b0 : fp[c];
            e[c] = !en[3-c] || cfg[7-2*c];
            if (en[3-c] && cfg[7-2*c])
                o[c] = ~((st[4+c] | duty[c]) ^ cfg[6-2*c]);
        end
        return {e, o};
    endfunction : exp_pins
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // Reset values, unmapped place, then corner and random configurations
    initial
    begin
        void'($urandom(62949));
        fan_pulse = 4'h9;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check({pin_oe, pin_out}, exp_pins(8'h00, 8'h00, 8'h00, 4'h0, 4'h9));
        rd(FPGR_OFS_IO_ENABLE, FPGR_RST_IO_ENABLE);
        rd(FPGR_OFS_DIR_POL, FPGR_RST_DIR_POL);
        rd(FPGR_OFS_LEVEL_STATE, FPGR_RST_LEVEL_STATE);
        wr(8'h7e, 8'hff);
        rd(8'h7e, 8'h00);
        rd(FPGR_OFS_IO_ENABLE, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 60; i++)
        begin
            @(negedge clk);
            fan_pulse = 4'($urandom);
            min_duty_lsb = (i < 4) ? 4'h0 : 4'($urandom);
            drv_val = 4'($urandom);
            // Reserved enable bits always written as zero
            wr(FPGR_OFS_IO_ENABLE, (i < 3) ? 8'h0f : 8'($urandom) & 8'h0f);
            wr(FPGR_OFS_DIR_POL, (i == 0) ? 8'haa : (i == 1) ? 8'h00 : (i == 2) ? 8'hff :
                8'($urandom));
            wr(FPGR_OFS_LEVEL_STATE, (i == 2) ? 8'h5a : 8'($urandom));
            exp_p = exp_pins(en_m, cfg_m, stat_m, min_duty_lsb, fan_pulse);
            drv_en = 4'($urandom) & ~exp_p[7:4];
            repeat (2) @(posedge clk);
            @(negedge clk);
            check({pin_oe, pin_out}, exp_p);
            rd(FPGR_OFS_LEVEL_STATE, exp_stat(en_m, cfg_m, stat_m, pin_level));
            rd(FPGR_OFS_DIR_POL, cfg_m);
            rd(FPGR_OFS_IO_ENABLE, en_m);
        end
        $display("test random configurations done");
        wr_rd(FPGR_OFS_IO_ENABLE, 8'h05);
        wr_rd(FPGR_OFS_DIR_POL, 8'h96);
        $display("test back-to-back done");
        // Reset in mid-run: pins fall back to fan pulse, registers clear
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check({pin_oe, pin_out}, 8'hf0);
        rst_n = 1'b1;
        @(negedge clk);
        check({pin_oe, pin_out}, {4'hf, fan_pulse});
        rd(FPGR_OFS_IO_ENABLE, FPGR_RST_IO_ENABLE);
        rd(FPGR_OFS_DIR_POL, FPGR_RST_DIR_POL);
        rd(FPGR_OFS_LEVEL_STATE, FPGR_RST_LEVEL_STATE);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule : fan_pin_gpio_reuse_test
`default_nettype wire

// file: tb/fpgr_board_model.sv
// Board logic sitting on the repurposed fan pins, resolving each pin level
`default_nettype none
module fpgr_board_model
(
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] drv_val,
    input wire logic [3:0] drv_en,
    output logic [3:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Device wins a clash so contention never turns into an unknown level
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (drv_en[i])
                pin_level[i] = drv_val[i];
            else
                pin_level[i] = 1'b1; // Pull-up on an idle pin
        end
    end
endmodule : fpgr_board_model
`default_nettype wire
